/* File: verilog/biu_pkg.sv */
// constants, encodings and register map of the bus interface unit
// Contract
// - stall the cpu while the queue holds fewer code bytes than requested.
// - prefetch when queue holds zero or one byte and cpu leaves the bus free.
// - even start address fetches two bytes, odd start address fetches one.
// - external 8-bit bus in expansion or microprocessor mode fetches one byte.
// - queue holds at most three code bytes.
// - branch, jump, call or interrupt empties the queue and refetches at target.
// - data requests wait while a transfer runs or a higher request is pending.
// - data read drives cpu address, samples memory during strobe low, cpu waits.
// - data write latches address and data, cpu continues at once.
// - posted write drives latched address and data during strobe low.
// - bus status decoded from strobe and read/write lines.
// - memory, i/o and control registers share one access path.
// - 24-bit address, bank from program or data bank, low 16 from pc/operand.
// - pc carry increments program bank, pc borrow decrements it.
// - all 256 banks in expansion/microprocessor mode, bank 0 only single-chip; a single-chip direct page access can still reach bank 1.
// - direct page is a 256-byte window from the base, may cross into bank 1.
// - bank 0 addresses 0x0000 to 0x007f decode as special function area.
// - odd word access or word on 8-bit external bus splits into two bytes.
// - cleared wait bit doubles external strobe low time, internal unaffected.
package biu_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PBANK = 8'h04;
	localparam logic [7:0] OFF_DBANK = 8'h08;
	localparam logic [7:0] OFF_DPAGE = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int CTRL_WAIT_BIT = 2;
	localparam int CTRL_BUS8_BIT = 3;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// special function area window in bank 0
	localparam logic [15:0] SFR_LO = 16'h0000;
	localparam logic [15:0] SFR_HI = 16'h007F;
	// strobe timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STROBE_LOW_NS = 10;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] LOW_NORM = 2'(STROBE_LOW_CYC);
	localparam logic [1:0] LOW_LONG = 2'(2 * STROBE_LOW_CYC);
	// bus status codes
	localparam logic [1:0] BUS_IDLE = 2'h0;
	localparam logic [1:0] BUS_READ = 2'h1;
	localparam logic [1:0] BUS_WRITE = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_READ = 4'h4,
		ST_WRITE = 4'h8
	} biu_state_e;
	typedef enum logic [1:0] {
		BS_IDLE = 2'h1,
		BS_LOW = 2'h2
	} bus_state_e;
endpackage

/* File: verilog/code_queue.sv */
// instruction prefetch queue, byte wide, shifts toward the head on pop
`timescale 1ns/1ps
module code_queue
	import biu_pkg::*;
#(
	parameter int DEPTH = 3
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic flush,
	input wire logic [1:0] push_n,
	input wire logic [15:0] push_data,
	input wire logic [1:0] pop_n,
	// state
	output logic [1:0] count,
	output logic [15:0] head
);
	generate
		if (DEPTH < 2 || DEPTH > 3)
			$error("code_queue depth must be 2 or 3");
	endgenerate

	logic [7:0] q_reg [DEPTH];
	logic [7:0] q_next [DEPTH];
	logic [1:0] count_reg;
	logic [1:0] count_next;

	always_comb
	begin
		q_next = q_reg;
		count_next = count_reg;
		if (flush)
			count_next = 2'h0;
		else
		begin
			for (int i = 0; i < DEPTH; i++)
				q_next[i] = (i + int'(pop_n) < DEPTH) ? q_reg[i + int'(pop_n)] : 8'h00;
			count_next = count_reg - pop_n;
			for (int j = 0; j < 2; j++)
			begin
				// never beyond depth, extra bytes are dropped
				if (j < int'(push_n) && int'(count_next) < DEPTH)
				begin
					q_next[count_next] = push_data[j*8 +: 8];
					count_next = count_next + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < DEPTH; i++)
				q_reg[i] <= 8'h00;
			count_reg <= 2'h0;
		end
		else
		begin
			q_reg <= q_next;
			count_reg <= count_next;
		end
	end

	assign count = count_reg;
	assign head = {q_reg[1], q_reg[0]};
endmodule

/* File: verilog/bus_cycle.sv */
// one strobe cycle on the memory bus, all pins from flip-flops
`timescale 1ns/1ps
module bus_cycle
	import biu_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request from the sequencer
	input wire logic start,
	input wire logic [23:0] addr,
	input wire logic we,
	input wire logic byte_mode,
	input wire logic [15:0] wdata,
	input wire logic ext,
	input wire logic wait_bit,
	output logic ready,
	output logic done,
	output logic [15:0] rdata,
	// memory bus
	output logic [23:0] mem_addr,
	output logic mem_strobe_n,
	output logic mem_rw,
	output logic mem_byte,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	output logic [1:0] bus_status,
	output logic sfr_sel
);
	bus_state_e st_reg, st_next;
	logic [1:0] cnt_reg, cnt_next;
	logic [23:0] addr_reg, addr_next;
	logic strobe_n_reg, strobe_n_next;
	logic rw_reg, rw_next;
	logic byte_reg, byte_next;
	logic [15:0] wd_reg, wd_next;
	logic [15:0] rd_reg, rd_next;
	logic done_reg, done_next;
	logic [1:0] status_reg, status_next;
	logic sfr_reg, sfr_next;

	always_comb
	begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		strobe_n_next = strobe_n_reg;
		rw_next = rw_reg;
		byte_next = byte_reg;
		wd_next = wd_reg;
		rd_next = rd_reg;
		done_next = 1'b0;
		sfr_next = sfr_reg;
		unique case (st_reg)
			BS_IDLE:
				if (start)
				begin
					st_next = BS_LOW;
					addr_next = addr;
					strobe_n_next = 1'b0;
					rw_next = !we;
					byte_next = byte_mode;
					wd_next = wdata;
					sfr_next = addr[23:16] == 8'h00 && addr[15:0] >= SFR_LO && addr[15:0] <= SFR_HI;
					cnt_next = (ext && !wait_bit) ? LOW_LONG - 2'h1 : LOW_NORM - 2'h1;
				end
			BS_LOW:
				if (cnt_reg == 2'h0)
				begin
					// read data is taken while the strobe is still low
					if (rw_reg)
						rd_next = mem_rdata;
					strobe_n_next = 1'b1;
					rw_next = 1'b1;
					done_next = 1'b1;
					st_next = BS_IDLE;
				end
				else
					cnt_next = cnt_reg - 2'h1;
			default:
				st_next = BS_IDLE;
		endcase
		// strobe high is idle, low with read/write high is read
		if (strobe_n_next)
			status_next = BUS_IDLE;
		else
			status_next = rw_next ? BUS_READ : BUS_WRITE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= BS_IDLE;
			cnt_reg <= 2'h0;
			addr_reg <= 24'h00_0000;
			strobe_n_reg <= 1'b1;
			rw_reg <= 1'b1;
			byte_reg <= 1'b0;
			wd_reg <= 16'h0000;
			rd_reg <= 16'h0000;
			done_reg <= 1'b0;
			status_reg <= BUS_IDLE;
			sfr_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			strobe_n_reg <= strobe_n_next;
			rw_reg <= rw_next;
			byte_reg <= byte_next;
			wd_reg <= wd_next;
			rd_reg <= rd_next;
			done_reg <= done_next;
			status_reg <= status_next;
			sfr_reg <= sfr_next;
		end
	end

	assign ready = st_reg == BS_IDLE;
	assign done = done_reg;
	assign rdata = rd_reg;
	assign mem_addr = addr_reg;
	assign mem_strobe_n = strobe_n_reg;
	assign mem_rw = rw_reg;
	assign mem_byte = byte_reg;
	assign mem_wdata = wd_reg;
	assign bus_status = status_reg;
	assign sfr_sel = sfr_reg;
endmodule

/* File: verilog/biu_top.sv */
// bus interface unit: prefetch queue, data path, bank logic and axi4-lite registers
`timescale 1ns/1ps
module biu_top
	import biu_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// cpu code port
	input wire logic code_req,
	input wire logic [1:0] code_need,
	output logic code_ack,
	output logic [15:0] code_data,
	output logic cpu_wait,
	input wire logic flush,
	input wire logic [15:0] flush_pc,
	input wire logic pc_borrow,
	input wire logic cpu_bus_next,
	// cpu data port
	input wire logic data_req,
	input wire logic data_we,
	input wire logic data_word,
	input wire logic data_dp,
	input wire logic [15:0] data_addr,
	input wire logic [15:0] data_wdata,
	output logic data_ack,
	output logic [15:0] data_rdata,
	// memory bus
	output logic [23:0] mem_addr,
	output logic mem_strobe_n,
	output logic mem_rw,
	output logic mem_byte,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	output logic [1:0] bus_status,
	output logic sfr_sel
);
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	biu_state_e st_reg, st_next;
	logic [3:0] ctrl_reg, ctrl_next;
	logic [7:0] pbank_reg, pbank_next;
	logic [7:0] dbank_reg, dbank_next;
	logic [15:0] dp_reg, dp_next;
	logic [15:0] fpc_reg, fpc_next;
	logic [23:0] op_addr_reg, op_addr_next;
	logic op_word_reg, op_word_next;
	logic op_split_reg, op_split_next;
	logic op_second_reg, op_second_next;
	logic op_ext_reg, op_ext_next;
	logic [15:0] op_data_reg, op_data_next;
	logic discard_reg, discard_next;
	logic code_ack_reg, code_ack_next;
	logic [15:0] code_data_reg, code_data_next;
	logic cpu_wait_reg, cpu_wait_next;
	logic data_ack_reg, data_ack_next;
	logic [15:0] data_rdata_reg, data_rdata_next;
	logic awready_reg, awready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	logic [1:0] q_count;
	logic [15:0] q_head;
	logic [1:0] q_push_n;
	logic [1:0] q_pop_n;
	logic q_flush;
	logic bus_start;
	logic [23:0] bus_addr;
	logic bus_we;
	logic bus_byte;
	logic [15:0] bus_wdata;
	logic bus_ext;
	logic bus_ready;
	logic bus_done;
	logic [15:0] bus_rdata;

	logic single;
	logic bus8;
	logic [7:0] eff_pbank;
	logic [7:0] eff_dbank;
	logic [23:0] faddr;
	logic fext;
	logic ftwo;
	logic [16:0] dp_sum;
	logic [23:0] daddr;
	logic dext;
	logic dsplit;
	logic code_short;
	logic [16:0] fpc_inc;

	always_comb
	begin
		single = ctrl_reg[1:0] == MODE_SINGLE;
		bus8 = ctrl_reg[CTRL_BUS8_BIT];
		// single-chip mode forces program and data bank to 0
		eff_pbank = single ? 8'h00 : pbank_reg;
		eff_dbank = single ? 8'h00 : dbank_reg;
		faddr = {eff_pbank, fpc_reg};
		fext = !single && faddr[23:16] != 8'h00;
		// two bytes from an even address unless the external bus is 8-bit
		ftwo = !fpc_reg[0] && !(fext && bus8);
		// direct page may run past bank 0 into bank 1
		dp_sum = {1'b0, dp_reg} + {9'h000, data_addr[7:0]};
		daddr = data_dp ? {7'h00, dp_sum} : {eff_dbank, data_addr};
		dext = !single && daddr[23:16] != 8'h00;
		dsplit = data_word && (daddr[0] || (dext && bus8));
		code_short = code_req && !code_ack_reg && q_count < code_need;
	end

	always_comb
	begin
		st_next = st_reg;
		ctrl_next = ctrl_reg;
		pbank_next = pbank_reg;
		dbank_next = dbank_reg;
		dp_next = dp_reg;
		fpc_next = fpc_reg;
		fpc_inc = 17'h0_0000;
		op_addr_next = op_addr_reg;
		op_word_next = op_word_reg;
		op_split_next = op_split_reg;
		op_second_next = op_second_reg;
		op_ext_next = op_ext_reg;
		op_data_next = op_data_reg;
		discard_next = discard_reg;
		code_ack_next = 1'b0;
		code_data_next = code_data_reg;
		data_ack_next = 1'b0;
		data_rdata_next = data_rdata_reg;
		q_push_n = 2'h0;
		q_pop_n = 2'h0;
		q_flush = 1'b0;
		bus_start = 1'b0;
		bus_addr = op_addr_reg + 24'h00_0001;
		bus_we = 1'b0;
		bus_byte = 1'b1;
		bus_wdata = 16'h0000;
		bus_ext = op_ext_reg;

		// hand over queued code with no stall when enough is there
		if (code_req && !code_ack_reg && !flush && code_need != 2'h0 && q_count >= code_need)
		begin
			code_ack_next = 1'b1;
			code_data_next = q_head;
			q_pop_n = code_need;
		end
		// cpu held while code is short or a read is outstanding
		cpu_wait_next = code_short || (data_req && !data_we && !data_ack_reg);

		unique case (st_reg)
			ST_IDLE:
				if (bus_ready)
				begin
					// data requests only start from idle, ahead of prefetch
					if (data_req && !data_ack_reg)
					begin
						op_addr_next = daddr;
						op_word_next = data_word;
						op_split_next = dsplit;
						op_second_next = 1'b0;
						op_ext_next = dext;
						op_data_next = data_wdata;
						bus_start = 1'b1;
						bus_addr = daddr;
						bus_we = data_we;
						bus_byte = !data_word || dsplit;
						bus_wdata = data_wdata;
						bus_ext = dext;
						if (data_we)
						begin
							// posted write, cpu released now
							data_ack_next = 1'b1;
							st_next = ST_WRITE;
						end
						else
							st_next = ST_READ;
					end
					else if (!flush && q_count <= 2'h1 && (code_short || !cpu_bus_next))
					begin
						op_addr_next = faddr;
						op_word_next = ftwo;
						op_ext_next = fext;
						discard_next = 1'b0;
						bus_start = 1'b1;
						bus_addr = faddr;
						bus_byte = !ftwo;
						bus_ext = fext;
						st_next = ST_FETCH;
					end
				end
			ST_FETCH:
				if (bus_done)
				begin
					if (!discard_reg && !flush)
					begin
						q_push_n = op_word_reg ? 2'h2 : 2'h1;
						fpc_inc = {1'b0, fpc_reg} + (op_word_reg ? 17'h0_0002 : 17'h0_0001);
						fpc_next = fpc_inc[15:0];
						// carry out of the bank moves to the next bank
						if (fpc_inc[16])
							pbank_next = pbank_reg + 8'h01;
					end
					st_next = ST_IDLE;
				end
			ST_READ:
				if (bus_done)
				begin
					if (op_split_reg && !op_second_reg)
					begin
						// second byte of a split word
						op_data_next = {8'h00, bus_rdata[7:0]};
						op_second_next = 1'b1;
						bus_start = 1'b1;
					end
					else
					begin
						if (op_second_reg)
							data_rdata_next = {bus_rdata[7:0], op_data_reg[7:0]};
						else if (op_word_reg)
							data_rdata_next = bus_rdata;
						else
							data_rdata_next = {8'h00, bus_rdata[7:0]};
						data_ack_next = 1'b1;
						st_next = ST_IDLE;
					end
				end
			ST_WRITE:
				if (bus_done)
				begin
					if (op_split_reg && !op_second_reg)
					begin
						op_second_next = 1'b1;
						bus_start = 1'b1;
						bus_we = 1'b1;
						bus_wdata = {8'h00, op_data_reg[15:8]};
					end
					else
						st_next = ST_IDLE;
				end
			default:
				st_next = ST_IDLE;
		endcase

		// queue dropped and refetch from the target; a fetch in flight is discarded
		if (flush)
		begin
			fpc_next = flush_pc;
			q_flush = 1'b1;
			if (st_reg == ST_FETCH && !bus_done)
				discard_next = 1'b1;
		end
		if (pc_borrow)
			pbank_next = pbank_next - 8'h01;

		// slave waits for address and data together, then answers one cycle later
		awready_next = awvalid && wvalid && !awready_reg && !bvalid_reg;
		bvalid_next = bvalid_reg && !bready;
		bresp_next = bresp_reg;
		if (awready_reg && awvalid && wvalid)
		begin
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			unique case (awaddr)
				OFF_CTRL: ctrl_next = 4'(merge({28'h000_0000, ctrl_reg}, wdata, wstrb));
				OFF_PBANK: pbank_next = 8'(merge({24'h00_0000, pbank_reg}, wdata, wstrb));
				OFF_DBANK: dbank_next = 8'(merge({24'h00_0000, dbank_reg}, wdata, wstrb));
				OFF_DPAGE: dp_next = 16'(merge({16'h0000, dp_reg}, wdata, wstrb));
				OFF_STATUS: bresp_next = RESP_OKAY;
				default: bresp_next = RESP_SLVERR;
			endcase
		end
		arready_next = arvalid && !arready_reg && !rvalid_reg;
		rvalid_next = rvalid_reg && !rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (arready_reg && arvalid)
		begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			unique case (araddr)
				OFF_CTRL: rdata_next = {28'h000_0000, ctrl_reg};
				OFF_PBANK: rdata_next = {24'h00_0000, pbank_reg};
				OFF_DBANK: rdata_next = {24'h00_0000, dbank_reg};
				OFF_DPAGE: rdata_next = {16'h0000, dp_reg};
				OFF_STATUS: rdata_next = {28'h000_0000, discard_reg, st_reg != ST_IDLE, q_count};
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= ST_IDLE;
			ctrl_reg <= CTRL_RESET;
			pbank_reg <= 8'h00;
			dbank_reg <= 8'h00;
			dp_reg <= 16'h0000;
			fpc_reg <= 16'h0000;
			op_addr_reg <= 24'h00_0000;
			op_word_reg <= 1'b0;
			op_split_reg <= 1'b0;
			op_second_reg <= 1'b0;
			op_ext_reg <= 1'b0;
			op_data_reg <= 16'h0000;
			discard_reg <= 1'b0;
			code_ack_reg <= 1'b0;
			code_data_reg <= 16'h0000;
			cpu_wait_reg <= 1'b0;
			data_ack_reg <= 1'b0;
			data_rdata_reg <= 16'h0000;
			awready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end
		else
		begin
			st_reg <= st_next;
			ctrl_reg <= ctrl_next;
			pbank_reg <= pbank_next;
			dbank_reg <= dbank_next;
			dp_reg <= dp_next;
			fpc_reg <= fpc_next;
			op_addr_reg <= op_addr_next;
			op_word_reg <= op_word_next;
			op_split_reg <= op_split_next;
			op_second_reg <= op_second_next;
			op_ext_reg <= op_ext_next;
			op_data_reg <= op_data_next;
			discard_reg <= discard_next;
			code_ack_reg <= code_ack_next;
			code_data_reg <= code_data_next;
			cpu_wait_reg <= cpu_wait_next;
			data_ack_reg <= data_ack_next;
			data_rdata_reg <= data_rdata_next;
			awready_reg <= awready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	code_queue #(.DEPTH(3)) u_queue (
		.aclk(aclk),
		.aresetn(aresetn),
		.flush(q_flush),
		.push_n(q_push_n),
		.push_data(bus_rdata),
		.pop_n(q_pop_n),
		.count(q_count),
		.head(q_head)
	);

	bus_cycle u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(bus_start),
		.addr(bus_addr),
		.we(bus_we),
		.byte_mode(bus_byte),
		.wdata(bus_wdata),
		.ext(bus_ext),
		.wait_bit(ctrl_reg[CTRL_WAIT_BIT]),
		.ready(bus_ready),
		.done(bus_done),
		.rdata(bus_rdata),
		.mem_addr(mem_addr),
		.mem_strobe_n(mem_strobe_n),
		.mem_rw(mem_rw),
		.mem_byte(mem_byte),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.bus_status(bus_status),
		.sfr_sel(sfr_sel)
	);

	assign awready = awready_reg;
	assign wready = awready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign code_ack = code_ack_reg;
	assign code_data = code_data_reg;
	assign cpu_wait = cpu_wait_reg;
	assign data_ack = data_ack_reg;
	assign data_rdata = data_rdata_reg;
endmodule

/* File: verif/biu_checker.sv */
// protocol assertions on the bus interface unit ports
`timescale 1ns/1ps
module biu_checker
	import biu_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// cpu side
	input wire logic code_req,
	input wire logic [1:0] code_need,
	input wire logic code_ack,
	input wire logic data_we,
	input wire logic data_dp,
	input wire logic [15:0] data_addr,
	input wire logic [15:0] data_wdata,
	input wire logic data_ack,
	// memory bus
	input wire logic [23:0] mem_addr,
	input wire logic mem_strobe_n,
	input wire logic mem_rw,
	input wire logic [15:0] mem_wdata,
	input wire logic [1:0] bus_status,
	input wire logic sfr_sel
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_BUS_STATUS: assert property (bus_status == (mem_strobe_n ? BUS_IDLE : (mem_rw ? BUS_READ : BUS_WRITE)))
		else $error("bus status decode wrong");
	AST_SFR_DECODE: assert property (!mem_strobe_n |-> sfr_sel == (mem_addr[23:7] == 17'h0_0000))
		else $error("special area select wrong");
	AST_INT_STROBE: assert property ($fell(mem_strobe_n) && mem_addr[23:16] == 8'h00 |=> mem_strobe_n)
		else $error("internal strobe stretched");
	AST_STROBE_MAX: assert property ((!mem_strobe_n) [*2] |=> mem_strobe_n)
		else $error("strobe low too long");
	AST_CODE_CAUSE: assert property (code_ack |-> $past(code_req) && $past(code_need) != 2'h0)
		else $error("code ack without request");
	// cpu holds its write request through the ack cycle, so no history is needed
	AST_WRITE_POSTED: assert property ($rose(data_ack) && data_we |-> !mem_strobe_n && !mem_rw
		&& mem_wdata[7:0] == data_wdata[7:0] && (data_dp || mem_addr[15:0] == data_addr))
		else $error("posted write not on bus");
	AST_READ_DONE: assert property ($rose(data_ack) && !data_we |-> $past(bus_status, 2) == BUS_READ)
		else $error("read ack before strobe");
	AST_DATA_IDLE: assert property ($rose(data_ack) |-> $past(mem_strobe_n))
		else $error("data taken while bus busy");
	COV_WRITE: cover property ($rose(data_ack) && data_we);
	COV_SFR: cover property (!mem_strobe_n && sfr_sel);
	COV_LONG: cover property ($fell(mem_strobe_n) ##1 !mem_strobe_n);
endmodule
bind biu_top biu_checker biu_checker_i (.aclk, .aresetn, .code_req, .code_need, .code_ack, .data_we, .data_dp,
	.data_addr, .data_wdata, .data_ack, .mem_addr, .mem_strobe_n, .mem_rw, .mem_wdata, .bus_status, .sfr_sel);

/* File: verif/biu_mem_model.sv */
// byte memory behind the strobe bus
`timescale 1ns/1ps
module biu_mem_model
(
	// clock
	input wire logic aclk,
	// memory bus
	input wire logic [23:0] mem_addr,
	input wire logic mem_strobe_n,
	input wire logic mem_rw,
	input wire logic mem_byte,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	logic [7:0] mem [logic [23:0]];
	logic [15:0] last = 16'h0000;
	function automatic logic [7:0] rd(input logic [23:0] a);
		return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A);
	endfunction
	// released bus shows inverted data so stale values never match
	always_comb
	begin
		if (!mem_strobe_n && mem_rw)
			mem_rdata = {mem_byte ? ~rd(mem_addr) : rd(mem_addr + 24'h00_0001), rd(mem_addr)};
		else
			mem_rdata = ~last;
	end
	always @(posedge aclk)
	begin
		if (!mem_strobe_n && mem_rw)
			last <= mem_rdata;
		if (!mem_strobe_n && !mem_rw)
		begin
			mem[mem_addr] = mem_wdata[7:0];
			if (!mem_byte)
				mem[mem_addr + 24'h00_0001] = mem_wdata[15:8];
		end
	end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the bus interface unit
`timescale 1ns/1ps
module testbench
	import biu_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, code_need, bus_status;
	logic code_req, flush, pc_borrow, cpu_bus_next, code_ack, cpu_wait, waited;
	logic data_req, data_we, data_word, data_dp, data_ack;
	logic [15:0] flush_pc, code_data, data_addr, data_wdata, data_rdata, mem_wdata, mem_rdata, cd;
	logic [23:0] mem_addr, l_addr;
	logic mem_strobe_n, mem_rw, mem_byte, sfr_sel, l_byte;
	logic sprev = 1'b1;
	int miscompares = 0, checks = 0, strobes = 0, lowc = 0, low_len = 0, n, s0;
	biu_top biu_top_i (.*);
	biu_mem_model biu_mem_model_i (.*);
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		sprev <= mem_strobe_n;
		lowc <= mem_strobe_n ? 0 : lowc + 1;
		if (mem_strobe_n && lowc != 0)
			low_len <= lowc;
		if (sprev && !mem_strobe_n)
		begin
			strobes <= strobes + 1;
			l_addr <= mem_addr;
			l_byte <= mem_byte;
		end
	end
	function automatic logic [7:0] mb(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		if (n >= 200)
			check(0, 1);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do @(posedge aclk); while (awready !== 1'b1 && ++n < 200);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 200);
		bready <= 1'b0;
		tmo();
		check(bresp, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do @(posedge aclk); while (arready !== 1'b1 && ++n < 200);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 200);
		rready <= 1'b0;
		rd = rdata;
		tmo();
		check(rresp, er);
	endtask
	task automatic code_get(input logic [1:0] need);
		@(posedge aclk);
		code_req <= 1'b1;
		code_need <= need;
		n = 0;
		waited = 1'b0;
		do
		begin
			@(posedge aclk);
			if (cpu_wait === 1'b1)
				waited = 1'b1;
		end while (code_ack !== 1'b1 && ++n < 200);
		code_req <= 1'b0;
		cd = code_data;
		tmo();
	endtask
	task automatic data_op(input logic we, input logic wd16, input logic dp, input logic [15:0] a, input logic [15:0] d);
		@(posedge aclk);
		data_req <= 1'b1;
		data_we <= we;
		data_word <= wd16;
		data_dp <= dp;
		data_addr <= a;
		data_wdata <= d;
		n = 0;
		do @(posedge aclk); while (data_ack !== 1'b1 && ++n < 200);
		data_req <= 1'b0;
		cd = data_rdata;
		tmo();
	endtask
	task automatic flush_to(input logic [15:0] pc, input logic nb);
		@(posedge aclk);
		flush <= 1'b1;
		flush_pc <= pc;
		cpu_bus_next <= nb;
		s0 = strobes;
		@(posedge aclk);
		flush <= 1'b0;
	endtask
	task automatic wait_strobe();
		n = 0;
		do @(posedge aclk); while (strobes == s0 && ++n < 200);
		tmo();
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, code_req, flush, pc_borrow, cpu_bus_next} = '0;
		{data_req, data_we, data_word, data_dp, awaddr, araddr, wdata, code_need, flush_pc, data_addr, data_wdata} = '0;
		wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			axi_rd(8'(4 * i), RESP_OKAY);
			check(rd, 32'h0000_0000);
		end
		axi_rd(8'h14, RESP_SLVERR);
		axi_wr(8'h14, 32'h0000_00FF, RESP_SLVERR);
		$display("test registers done");
		flush_to(16'h2001, 1'b0);
		wait_strobe();
		check(l_addr, 24'h00_2001);
		check(l_byte, 1'b1);
		repeat (20) @(posedge aclk);
		axi_rd(OFF_STATUS, RESP_OKAY);
		check(rd[1:0], 2'h3);
		code_get(2'h2);
		check(n, 1);
		check(cd, {mb(24'h00_2002), mb(24'h00_2001)});
		code_get(2'h1);
		check(cd[7:0], mb(24'h00_2003));
		$display("test prefetch done");
		repeat (10) @(posedge aclk);
		flush_to(16'h3000, 1'b1);
		repeat (10) @(posedge aclk);
		check(strobes, s0);
		code_get(2'h2);
		check(waited, 1'b1);
		check(cd, {mb(24'h00_3001), mb(24'h00_3000)});
		$display("test stall done");
		data_op(1'b1, 1'b1, 1'b0, 16'h0300, 16'hBEEF);
		check(n, 1);
		data_op(1'b0, 1'b1, 1'b0, 16'h0300, 16'h0000);
		check(cd, 16'hBEEF);
		s0 = strobes;
		data_op(1'b0, 1'b1, 1'b0, 16'h0301, 16'h0000);
		check(cd, {mb(24'h00_0302), 8'hBE});
		check(strobes - s0, 2);
		data_op(1'b0, 1'b0, 1'b0, 16'h0040, 16'h0000);
		check(cd, {8'h00, mb(24'h00_0040)});
		axi_wr(OFF_CTRL, 32'h0000_0005, RESP_OKAY);
		axi_wr(OFF_DBANK, 32'h0000_0002, RESP_OKAY);
		data_op(1'b0, 1'b0, 1'b0, 16'h0010, 16'h0000);
		check(cd[7:0], mb(24'h02_0010));
		check(low_len, 1);
		axi_wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		data_op(1'b0, 1'b0, 1'b0, 16'h0010, 16'h0000);
		check(low_len, 2);
		axi_wr(OFF_DPAGE, 32'h0000_FFC0, RESP_OKAY);
		data_op(1'b0, 1'b0, 1'b1, 16'h0050, 16'h0000);
		check(cd[7:0], mb(24'h01_0010));
		$display("test data done");
		axi_wr(OFF_CTRL, 32'h0000_0005, RESP_OKAY);
		flush_to(16'hFFFF, 1'b1);
		code_get(2'h2);
		check(cd, {mb(24'h01_0000), mb(24'h00_FFFF)});
		axi_rd(OFF_PBANK, RESP_OKAY);
		check(rd, 32'h0000_0001);
		@(posedge aclk);
		pc_borrow <= 1'b1;
		@(posedge aclk);
		pc_borrow <= 1'b0;
		axi_rd(OFF_PBANK, RESP_OKAY);
		check(rd, 32'h0000_0000);
		axi_wr(OFF_CTRL, 32'h0000_000D, RESP_OKAY);
		axi_wr(OFF_PBANK, 32'h0000_0001, RESP_OKAY);
		flush_to(16'h4000, 1'b0);
		wait_strobe();
		check(l_addr, 24'h01_4000);
		check(l_byte, 1'b1);
		$display("test banks done");
		end_of_test();
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule
